//--- hdl/gyro_diag_pkg.sv
// Purpose: Shared constants and types for the diagnostics and alarm unit
// Assumes: 16-bit serial frames, byte-addressed 16-bit registers
// Notes: A word register sits at an even address, high byte at odd address
package gyro_diag_pkg;

	// ------------------------------------------------------------------
	// Serial frame and register map
	// ------------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [6:0] MAG1_ADDR = 7'h20;
	localparam logic [6:0] MAG2_ADDR = 7'h22;
	localparam logic [6:0] SMPL1_ADDR = 7'h24;
	localparam logic [6:0] SMPL2_ADDR = 7'h26;
	localparam logic [6:0] CTRL_ADDR = 7'h28;
	localparam logic [6:0] MISC_ADDR = 7'h34;
	localparam logic [6:0] DIAG_ADDR = 7'h3C;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] MISC_MASK = 16'h0F07;
	localparam logic [15:0] DIAG_MASK = 16'h037F;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int MISC_MEMTEST = 11;
	localparam int MISC_SELFTEST = 10;
	localparam int MISC_DRDY_EN = 2;
	localparam int MISC_DRDY_POL = 1;
	localparam int MISC_DRDY_SEL = 0;
	localparam int CFG_ROC2 = 15;
	localparam int CFG_ROC1 = 11;
	localparam int CFG_FILT = 4;
	localparam int CFG_OUT_EN = 2;
	localparam int CFG_OUT_POL = 1;
	localparam int CFG_OUT_SEL = 0;
	localparam int DIAG_ALM1 = 8;
	localparam int DIAG_CSUM = 6;
	localparam int DIAG_ST = 5;
	localparam int DIAG_OVR = 4;
	localparam int DIAG_SPI = 3;
	localparam int DIAG_FLASH = 2;
	localparam int DIAG_HI = 1;
	localparam int DIAG_LO = 0;
	localparam int THR_DIR = 15;

	// ------------------------------------------------------------------
	// Codes, limits and types
	// ------------------------------------------------------------------
	localparam logic [1:0] MAN_NEG = 2'b10;
	localparam logic [1:0] MAN_POS = 2'b01;
	localparam logic [2:0] SRC_SUPPLY = 3'b001;
	localparam logic [2:0] SRC_RATE = 3'b010;
	localparam logic [2:0] SRC_AUX = 3'b101;
	localparam logic [2:0] SRC_TEMP = 3'b110;
	localparam logic [7:0] ST_SETTLE = 8'h08;
	localparam logic signed [14:0] ST_MIN = 15'sh0040;
	localparam logic signed [14:0] ST_MAX = 15'sh1000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BASE = 2'b01,
		ST_STIM = 2'b10,
		ST_EVAL = 2'b11
	} st_state_t;

	typedef struct packed {
		logic [13:0] rate_raw;
		logic [13:0] rate_filt;
		logic [13:0] supply;
		logic [13:0] aux;
		logic [13:0] temp;
	} sensor_t;

endpackage

//--- hdl/gyro_diagnostics_alarms.sv
// Purpose: Self-test, memory test, diagnostic flags and two alarms
// Assumes: sample_tick is one pulse per sample period on the same clock
// Notes: Serial port is sampled by the system clock, mode 3, MSB first
// Behaviour
// - Self-test trigger exercises, measures, decides, records, resumes
// - Self-test trigger bit clears itself when the routine ends
// - Manual bits: 10 negative stimulus, 01 positive, zero removes it
// - Memory test bit runs checksum compare, result lands in flag 6
// - Reading the diagnostic word clears its error flags
// - A persisting fault sets its flag again on the next sample
// - Supply flags clear by themselves once supply is in range
// - Flag positions: alarms 9/8, checksum 6, self-test 5, 4, 3, 2
// - Bit 1 while supply above 5.25 V, bit 0 below 4.75 V
// - Alarm source selector: off, supply, rate, auxiliary, temperature
// - Per-alarm mode bit chooses rate-of-change or static comparison
// - Configuration bit 4 selects filtered or unfiltered rate data
// - Indicator enable bit 2, polarity bit 1, line select bit 0
// - Threshold bit 15 is direction, bits 13..0 the threshold
// - Sample count window in bits 7..0, zero and one mean one
// - Rate-of-change period is sample count times sample period
// - I/O lines: data ready first, then alarm, then general purpose
`timescale 1ns/100ps
module gyro_diagnostics_alarms
	import gyro_diag_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic sample_tick,
	input wire sensor_t sensor,
	input wire logic supply_high,
	input wire logic supply_low,
	input wire logic overrange,
	input wire logic flash_update_fail,
	input wire logic mem_check_done,
	input wire logic mem_check_fail,
	output logic mem_check_req,
	output logic stim_pos,
	output logic stim_neg,
	input wire logic data_ready,
	input wire logic [1:0] gpio_out,
	input wire logic [1:0] gpio_oe,
	output logic io_line_one_out,
	output logic io_line_one_oe,
	output logic io_line_two_out,
	output logic io_line_two_oe
);

	// ------------------------------------------------------------------
	// Pin synchronisers and serial port
	// ------------------------------------------------------------------
	logic [2:0] pin_meta_reg, pin_sync_reg;
	logic sclk_prev_reg, cs_prev_reg, sdo_oe_reg;
	logic [15:0] rx_reg, rx_next, tx_reg, tx_next, rd_word;
	logic [4:0] bit_cnt_reg, bit_cnt_next;
	logic cs_s, sclk_s, sdi_s, frame_end, frame_bad, do_wr, do_rd_diag;
	logic [6:0] word_addr;
	logic [15:0] mag_reg [2];
	logic [15:0] smpl_reg [2];
	logic [15:0] mag_next [2];
	logic [15:0] smpl_next [2];
	logic [15:0] cfg_reg, cfg_next, misc_reg, misc_next;
	logic [15:0] diag_reg, diag_next, diag_set;
	logic [1:0] alarm_act, alarm_hit;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Only the second stage is read; cs idles high, sclk idles high
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pin_meta_reg <= 3'h6;
			pin_sync_reg <= 3'h6;
		end
		else
		begin
			pin_meta_reg <= {spi_cs_n, spi_sclk, spi_sdi};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign cs_s = pin_sync_reg[2];
	assign sclk_s = pin_sync_reg[1];
	assign sdi_s = pin_sync_reg[0];
	assign word_addr = {rx_reg[14:9], 1'b0};

	// Shift in on rising sclk, out on falling; act on cs release
	always_comb
	begin
		rx_next = rx_reg;
		tx_next = tx_reg;
		bit_cnt_next = bit_cnt_reg;
		frame_end = cs_s && !cs_prev_reg && bit_cnt_reg == FRAME_BITS;
		frame_bad = cs_s && !cs_prev_reg && bit_cnt_reg != FRAME_BITS
			&& bit_cnt_reg != 5'h00;
		do_wr = frame_end && rx_reg[15];
		do_rd_diag = frame_end && !rx_reg[15] && word_addr == DIAG_ADDR;
		if (!cs_s && sclk_s && !sclk_prev_reg)
		begin
			rx_next = {rx_reg[14:0], sdi_s};
			if (bit_cnt_reg != 5'h1F)
				bit_cnt_next = bit_cnt_reg + 5'h01;
		end
		if (!cs_s && !sclk_s && sclk_prev_reg)
			tx_next = {tx_reg[14:0], 1'b0};
		if (cs_s)
			bit_cnt_next = 5'h00;
		// Read answer goes out in the following frame
		if (frame_end && !rx_reg[15])
			tx_next = rd_word;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sclk_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			sdo_oe_reg <= 1'b0;
			rx_reg <= REG_RESET;
			tx_reg <= REG_RESET;
			bit_cnt_reg <= 5'h00;
		end
		else
		begin
			sclk_prev_reg <= sclk_s;
			cs_prev_reg <= cs_s;
			sdo_oe_reg <= !cs_s;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	assign spi_sdo = tx_reg[15];
	assign spi_sdo_oe = sdo_oe_reg;

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	function automatic logic [15:0] put_byte(input logic [15:0] old,
		input logic hi, input logic [7:0] d);
		put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
	endfunction

	// Unmapped addresses read as zero
	always_comb
	begin
		case (word_addr)
			MAG1_ADDR: rd_word = mag_reg[0];
			MAG2_ADDR: rd_word = mag_reg[1];
			SMPL1_ADDR: rd_word = smpl_reg[0];
			SMPL2_ADDR: rd_word = smpl_reg[1];
			CTRL_ADDR: rd_word = cfg_reg;
			MISC_ADDR: rd_word = misc_reg;
			DIAG_ADDR: rd_word = diag_reg;
			default: rd_word = REG_RESET;
		endcase
	end

	st_state_t st_state_reg, st_state_next;
	logic [7:0] st_cnt_reg, st_cnt_next;
	logic [13:0] st_base_reg, st_base_next;
	logic st_bad_reg, st_bad_next, mem_bad_reg, mem_bad_next, mem_fin;
	logic signed [14:0] st_delta;

	assign mem_fin = mem_check_done && misc_reg[MISC_MEMTEST];

	// Hardware clears of the trigger bits win over a same-cycle write
	always_comb
	begin
		mag_next = mag_reg;
		smpl_next = smpl_reg;
		cfg_next = cfg_reg;
		misc_next = misc_reg;
		if (do_wr)
		begin
			case (word_addr)
				MAG1_ADDR: mag_next[0] = put_byte(mag_reg[0], rx_reg[8],
					rx_reg[7:0]);
				MAG2_ADDR: mag_next[1] = put_byte(mag_reg[1], rx_reg[8],
					rx_reg[7:0]);
				SMPL1_ADDR: smpl_next[0] = put_byte(smpl_reg[0], rx_reg[8],
					rx_reg[7:0]);
				SMPL2_ADDR: smpl_next[1] = put_byte(smpl_reg[1], rx_reg[8],
					rx_reg[7:0]);
				CTRL_ADDR: cfg_next = put_byte(cfg_reg, rx_reg[8],
					rx_reg[7:0]);
				MISC_ADDR: misc_next = put_byte(misc_reg, rx_reg[8],
					rx_reg[7:0]) & MISC_MASK;
				default: misc_next = misc_reg;
			endcase
		end
		if (st_state_reg == ST_EVAL)
			misc_next[MISC_SELFTEST] = 1'b0;
		if (mem_fin)
			misc_next[MISC_MEMTEST] = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			mag_reg <= '{REG_RESET, REG_RESET};
			smpl_reg <= '{REG_RESET, REG_RESET};
			cfg_reg <= REG_RESET;
			misc_reg <= REG_RESET;
		end
		else
		begin
			mag_reg <= mag_next;
			smpl_reg <= smpl_next;
			cfg_reg <= cfg_next;
			misc_reg <= misc_next;
		end
	end

	// ------------------------------------------------------------------
	// Self-test sequencer and memory test
	// ------------------------------------------------------------------
	assign st_delta = $signed({sensor.rate_filt[13], sensor.rate_filt})
		- $signed({st_base_reg[13], st_base_reg});

	// Baseline, then positive stimulus, then a window check on the shift
	always_comb
	begin
		st_state_next = st_state_reg;
		st_cnt_next = st_cnt_reg;
		st_base_next = st_base_reg;
		st_bad_next = st_bad_reg;
		mem_bad_next = mem_fin ? mem_check_fail : mem_bad_reg;
		if (sample_tick && st_state_reg != ST_IDLE)
			st_cnt_next = st_cnt_reg + 8'h01;
		case (st_state_reg)
			ST_IDLE:
				if (misc_reg[MISC_SELFTEST])
				begin
					st_state_next = ST_BASE;
					st_cnt_next = 8'h00;
				end
			ST_BASE:
				if (sample_tick && st_cnt_reg == ST_SETTLE)
				begin
					st_base_next = sensor.rate_filt;
					st_state_next = ST_STIM;
					st_cnt_next = 8'h00;
				end
			ST_STIM:
				if (sample_tick && st_cnt_reg == ST_SETTLE)
				begin
					st_bad_next = st_delta < ST_MIN || st_delta > ST_MAX;
					st_state_next = ST_EVAL;
				end
			ST_EVAL: st_state_next = ST_IDLE;
			default: st_state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st_state_reg <= ST_IDLE;
			st_cnt_reg <= 8'h00;
			st_base_reg <= 14'h0000;
			st_bad_reg <= 1'b0;
			mem_bad_reg <= 1'b0;
			stim_pos <= 1'b0;
			stim_neg <= 1'b0;
			mem_check_req <= 1'b0;
		end
		else
		begin
			st_state_reg <= st_state_next;
			st_cnt_reg <= st_cnt_next;
			st_base_reg <= st_base_next;
			st_bad_reg <= st_bad_next;
			mem_bad_reg <= mem_bad_next;
			// Manual stimulus only while the routine is idle
			stim_pos <= st_state_reg == ST_STIM || (st_state_reg == ST_IDLE
				&& misc_reg[9:8] == MAN_POS);
			stim_neg <= st_state_reg == ST_IDLE
				&& misc_reg[9:8] == MAN_NEG;
			mem_check_req <= misc_next[MISC_MEMTEST];
		end
	end

	sequence st_finish_s;
		st_state_reg == ST_EVAL ##1 st_state_reg == ST_IDLE;
	endsequence
	st_trigger_clear_a: assert property (st_finish_s |->
		!misc_reg[MISC_SELFTEST]) else $error("self-test bit not cleared");
	st_result_a: assert property (st_state_reg == ST_EVAL && st_bad_reg
		|=> diag_reg[DIAG_ST]) else $error("self-test fail not recorded");
	manual_stim_a: assert property (st_state_reg == ST_IDLE
		&& misc_reg[9:8] == MAN_NEG |=> stim_neg && !stim_pos)
		else $error("negative stimulus not applied");
	mem_result_a: assert property (mem_fin && mem_check_fail
		|=> diag_reg[DIAG_CSUM] && !misc_reg[MISC_MEMTEST])
		else $error("checksum result not stored");

	// ------------------------------------------------------------------
	// Diagnostic flags
	// ------------------------------------------------------------------
	// Set wins over the read clear so no fault is lost in that cycle
	always_comb
	begin
		diag_set = REG_RESET;
		if (sample_tick)
		begin
			// This sample's compare, so a stale alarm is never flagged
			diag_set[DIAG_ALM1 + 1:DIAG_ALM1] = alarm_hit;
			diag_set[DIAG_CSUM] = mem_bad_reg;
			diag_set[DIAG_ST] = st_bad_reg;
			diag_set[DIAG_OVR] = overrange;
			diag_set[DIAG_FLASH] = flash_update_fail;
		end
		diag_set[DIAG_SPI] = frame_bad;
		diag_set[DIAG_ST] = diag_set[DIAG_ST]
			|| (st_state_reg == ST_EVAL && st_bad_reg);
		diag_set[DIAG_CSUM] = diag_set[DIAG_CSUM]
			|| (mem_fin && mem_check_fail);
		diag_next = ((do_rd_diag ? REG_RESET : diag_reg) | diag_set)
			& DIAG_MASK;
		diag_next[DIAG_HI] = supply_high;
		diag_next[DIAG_LO] = supply_low;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			diag_reg <= REG_RESET;
		else
			diag_reg <= diag_next;
	end

	diag_clear_a: assert property (do_rd_diag && !sample_tick
		|=> diag_reg[9:8] == 2'b00) else $error("read did not clear alarms");
	diag_reset_a: assert property (sample_tick && alarm_hit[0]
		|=> diag_reg[DIAG_ALM1]) else $error("alarm flag not set again");
	supply_flag_a: assert property (##1 diag_reg[1:0] ==
		$past({supply_high, supply_low})) else $error("supply flags wrong");

	// ------------------------------------------------------------------
	// Alarm evaluation, one per alarm
	// ------------------------------------------------------------------
	// Sources are taken as twos complement; history follows the
	// selected source, so a source change needs a window to settle
	for (genvar i = 0; i < 2; i++)
	begin : g_alarm
		logic [13:0] hist [256];
		logic [13:0] val, old;
		logic [7:0] ptr_reg, ptr_next, n, rd_idx;
		logic [2:0] sel;
		logic ok, hit, act_reg, act_next;
		logic signed [14:0] cmp, thr;

		always_comb
		begin
			sel = (i == 0) ? cfg_reg[10:8] : cfg_reg[14:12];
			ok = 1'b1;
			case (sel)
				SRC_SUPPLY: val = sensor.supply;
				SRC_RATE: val = cfg_reg[CFG_FILT] ? sensor.rate_filt
					: sensor.rate_raw;
				SRC_AUX: val = sensor.aux;
				SRC_TEMP: val = sensor.temp;
				default:
				begin
					val = 14'h0000;
					ok = 1'b0;
				end
			endcase
			n = (smpl_reg[i][7:0] < 8'h02) ? 8'h01 : smpl_reg[i][7:0];
			rd_idx = ptr_reg - n;
			old = hist[rd_idx];
			thr = $signed({mag_reg[i][13], mag_reg[i][13:0]});
			cmp = cfg_reg[(i == 0) ? CFG_ROC1 : CFG_ROC2]
				? $signed({val[13], val}) - $signed({old[13], old})
				: $signed({val[13], val});
			hit = ok && (mag_reg[i][THR_DIR] ? cmp > thr : cmp < thr);
			act_next = sample_tick ? hit : act_reg;
			ptr_next = sample_tick ? ptr_reg + 8'h01 : ptr_reg;
		end

		always_ff @(posedge clock)
		begin
			if (sys_rst)
			begin
				ptr_reg <= 8'h00;
				act_reg <= 1'b0;
			end
			else
			begin
				ptr_reg <= ptr_next;
				act_reg <= act_next;
			end
		end

		// One entry per sample period
		always_ff @(posedge clock)
		begin
			if (sample_tick)
				hist[ptr_reg] <= val;
		end

		assign alarm_act[i] = act_reg;
		assign alarm_hit[i] = sample_tick && hit;
	end

	alarm_static_a: assert property (sample_tick
		&& cfg_reg[14:12] == SRC_TEMP && !cfg_reg[CFG_ROC2]
		&& mag_reg[1][THR_DIR] && $signed({sensor.temp[13], sensor.temp})
		> $signed({mag_reg[1][13], mag_reg[1][13:0]}) |=> alarm_act[1])
		else $error("static alarm missed");

	// ------------------------------------------------------------------
	// Digital I/O line ownership
	// ------------------------------------------------------------------
	logic [1:0] io_out_reg, io_out_next, io_oe_reg, io_oe_next;
	logic drdy_lvl, alm_lvl;

	// Data ready claims its line first, then the alarm, then GPIO
	always_comb
	begin
		drdy_lvl = misc_reg[MISC_DRDY_POL] ? data_ready : !data_ready;
		alm_lvl = cfg_reg[CFG_OUT_POL] ? |alarm_act : !(|alarm_act);
		for (int k = 0; k < 2; k++)
		begin
			if (misc_reg[MISC_DRDY_EN] && misc_reg[MISC_DRDY_SEL] == k[0])
			begin
				io_out_next[k] = drdy_lvl;
				io_oe_next[k] = 1'b1;
			end
			else if (cfg_reg[CFG_OUT_EN] && cfg_reg[CFG_OUT_SEL] == k[0])
			begin
				io_out_next[k] = alm_lvl;
				io_oe_next[k] = 1'b1;
			end
			else
			begin
				io_out_next[k] = gpio_out[k];
				io_oe_next[k] = gpio_oe[k];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			io_out_reg <= 2'b00;
			io_oe_reg <= 2'b00;
		end
		else
		begin
			io_out_reg <= io_out_next;
			io_oe_reg <= io_oe_next;
		end
	end

	assign io_line_one_out = io_out_reg[0];
	assign io_line_one_oe = io_oe_reg[0];
	assign io_line_two_out = io_out_reg[1];
	assign io_line_two_oe = io_oe_reg[1];

	alarm_line_a: assert property (cfg_reg[2:0] == 3'b111
		&& !misc_reg[MISC_DRDY_EN] && (|alarm_act)
		|=> io_oe_reg[1] && io_out_reg[1]) else $error("indicator not active");

endmodule

//--- sim/gyro_diagnostics_alarms_test.sv
// Purpose: Self-checking bench for the diagnostics and alarm unit
// Assumes: Reads answer in the frame after the command frame
// Notes: Fault levels and sensor words are driven straight at the ports
`timescale 1ns/100ps
module gyro_diagnostics_alarms_test
	import gyro_diag_pkg::*;
;
	logic clock, sys_rst, sample_tick, data_ready;
	logic supply_high, supply_low, overrange, flash_update_fail;
	logic mem_check_done, mem_check_fail, mem_check_req;
	logic [1:0] gpio_out, gpio_oe;
	sensor_t sensor;
	logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic stim_pos, stim_neg;
	logic io_line_one_out, io_line_one_oe, io_line_two_out, io_line_two_oe;
	int failures = 0;
	int n_tests = 0;

	// ------------------------------------------------------------------
	// Design, host model and clock
	// ------------------------------------------------------------------
	gyro_diagnostics_alarms dut (.clock(clock), .sys_rst(sys_rst),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
		.sample_tick(sample_tick), .sensor(sensor),
		.supply_high(supply_high), .supply_low(supply_low),
		.overrange(overrange), .flash_update_fail(flash_update_fail),
		.mem_check_done(mem_check_done), .mem_check_fail(mem_check_fail),
		.mem_check_req(mem_check_req), .stim_pos(stim_pos),
		.stim_neg(stim_neg), .data_ready(data_ready), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .io_line_one_out(io_line_one_out),
		.io_line_one_oe(io_line_one_oe), .io_line_two_out(io_line_two_out),
		.io_line_two_oe(io_line_two_oe));

	host_spi_model host (.clock(clock), .spi_sdo(spi_sdo),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

	// Free-running 10 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host.xfer({1'b1, a, d}, 16, r);
	endtask

	// Word writes go high byte first, as two byte frames
	task automatic wrw(input logic [6:0] a, input logic [15:0] d);
		wr(a | 7'h01, d[15:8]);
		wr(a, d[7:0]);
	endtask

	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		logic [15:0] r;
		host.xfer({1'b0, a, 8'h00}, 16, r);
		host.xfer(16'h0000, 16, v);
	endtask

	// One sample pulse, then room for the registered outputs to settle
	task automatic tick();
		@(negedge clock);
		sample_tick = 1'b1;
		@(negedge clock);
		sample_tick = 1'b0;
		repeat (4) @(negedge clock);
	endtask

	task automatic raw_tick(input logic [13:0] raw);
		@(negedge clock);
		sensor.rate_raw = raw;
		tick();
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		logic [15:0] v;
		rd(CTRL_ADDR, v);
		chk(v, REG_RESET);
		wrw(MAG2_ADDR, 16'h3F00);
		rd(MAG2_ADDR, v);
		chk(v, 16'h3F00);
		wrw(SMPL2_ADDR, 16'h00A5);
		rd(SMPL2_ADDR, v);
		chk(v, 16'h00A5);
		wr(7'h7E, 8'h5A);
		rd(7'h7E, v);
		chk(v, 16'h0000);
		wrw(DIAG_ADDR, 16'h037F);
		rd(DIAG_ADDR, v);
		chk(v, 16'h0000);
	endtask

	task automatic t_diag();
		logic [15:0] v;
		@(negedge clock);
		overrange = 1'b1;
		tick();
		rd(DIAG_ADDR, v);
		chk(v, 16'h0010);
		rd(DIAG_ADDR, v);
		chk(v, 16'h0000);
		tick();
		rd(DIAG_ADDR, v);
		chk(v, 16'h0010);
		{overrange, flash_update_fail} = 2'b01;
		tick();
		flash_update_fail = 1'b0;
		rd(DIAG_ADDR, v);
		chk(v, 16'h0004);
		supply_low = 1'b1;
		rd(DIAG_ADDR, v);
		chk(v, 16'h0001);
		{supply_low, supply_high} = 2'b01;
		rd(DIAG_ADDR, v);
		chk(v, 16'h0002);
		supply_high = 1'b0;
		// Short frame; the reply driver must be enabled while selected
		fork
			host.xfer(16'h2000, 8, v);
			begin
				repeat (20) @(negedge clock);
				chk(16'(spi_sdo_oe), 16'h0001);
			end
		join
		chk(16'(spi_sdo_oe), 16'h0000);
		rd(DIAG_ADDR, v);
		chk(v, 16'h0008);
	endtask

	task automatic t_manual();
		logic [1:0] p[3] = '{2'b10, 2'b01, 2'b00};
		int i;
		for (i = 0; i < 3; i++)
		begin
			wr(MISC_ADDR | 7'h01, {6'h00, p[i]});
			chk(16'({stim_neg, stim_pos}), 16'(p[i]));
		end
	endtask

	// The sensor answers the stimulus by resp while it is applied
	task automatic t_selftest(input logic [13:0] resp,
		input logic [15:0] exp);
		logic [15:0] v;
		logic seen;
		int i;
		seen = 1'b0;
		wr(MISC_ADDR | 7'h01, 8'h04);
		for (i = 0; i < 25; i++)
		begin
			@(negedge clock);
			sensor.rate_filt = stim_pos ? resp : 14'h0000;
			seen = seen | stim_pos;
			tick();
		end
		chk(16'({seen, stim_pos}), 16'h0002);
		rd(MISC_ADDR, v);
		chk(v & 16'h0400, 16'h0000);
		rd(DIAG_ADDR, v);
		chk(v, exp);
	endtask

	// Every source code, static greater-than, indicator on line two
	task automatic t_sources();
		logic [15:0] v;
		logic u;
		int c;
		wrw(MAG2_ADDR, 16'h8100);
		wr(CTRL_ADDR, 8'h17);
		for (c = 0; c < 8; c++)
		begin
			u = !(c inside {1, 2, 5, 6});
			@(negedge clock);
			sensor.rate_raw = (c == 2 || u) ? 14'h0200 : 14'h0000;
			sensor.rate_filt = (c == 2 || u) ? 14'h0200 : 14'h0000;
			sensor.supply = (c == 1 || u) ? 14'h0200 : 14'h0000;
			sensor.aux = (c == 5 || u) ? 14'h0200 : 14'h0000;
			sensor.temp = (c == 6 || u) ? 14'h0200 : 14'h0000;
			wr(CTRL_ADDR | 7'h01, {1'b0, c[2:0], 4'h0});
			tick();
			chk(16'({io_line_two_oe, io_line_two_out}),
				16'({1'b1, !u}));
		end
		wr(CTRL_ADDR | 7'h01, 8'h20);
		sensor.rate_filt = 14'h0000;
		tick();
		chk(16'(io_line_two_out), 16'h0000);
		wr(CTRL_ADDR, 8'h07);
		tick();
		chk(16'(io_line_two_out), 16'h0001);
		wrw(MAG2_ADDR, 16'h3F00);
		raw_tick(14'h0000);
		chk(16'(io_line_two_out), 16'h0000);
		raw_tick(14'h3E00);
		chk(16'(io_line_two_out), 16'h0001);
		rd(DIAG_ADDR, v);
		chk(v, 16'h0200);
		wrw(CTRL_ADDR, 16'h0000);
		chk(16'({io_line_one_oe, io_line_two_oe}), 16'h0000);
	endtask

	task automatic t_memtest();
		logic [15:0] v;
		wr(MISC_ADDR | 7'h01, 8'h08);
		chk(16'(mem_check_req), 16'h0001);
		// Step off the edge so the done pulse spans a whole clock
		@(negedge clock);
		{mem_check_done, mem_check_fail} = 2'b11;
		@(negedge clock);
		{mem_check_done, mem_check_fail} = 2'b00;
		repeat (3) @(negedge clock);
		chk(16'(mem_check_req), 16'h0000);
		rd(DIAG_ADDR, v);
		chk(v, 16'h0040);
	endtask

	// Ramp of 0x60 a sample: only a window of 3 exceeds 0x100
	task automatic t_roc();
		int i;
		logic [3:0] io;
		wrw(MAG1_ADDR, 16'h8100);
		wr(SMPL1_ADDR, 8'h01);
		wrw(CTRL_ADDR, 16'h0A04);
		raw_tick(14'h0000);
		raw_tick(14'h0000);
		for (i = 1; i < 9; i++)
		begin
			if (i == 5) wr(SMPL1_ADDR, 8'h03);
			if (i == 8) wr(SMPL1_ADDR, 8'h00);
			raw_tick(14'(i * 96));
			chk(16'({io_line_one_oe, io_line_one_out}),
				16'({1'b1, !(i inside {5, 6, 7})}));
		end
		wr(MISC_ADDR, 8'h06);
		{gpio_oe, gpio_out, data_ready} = 5'h15;
		repeat (3) @(negedge clock);
		io = {io_line_one_oe, io_line_one_out,
			io_line_two_oe, io_line_two_out};
		chk(16'(io), 16'h000F);
		data_ready = 1'b0;
		repeat (3) @(negedge clock);
		io = {io_line_one_oe, io_line_one_out,
			io_line_two_oe, io_line_two_out};
		chk(16'(io), 16'h000B);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		{sys_rst, sample_tick, data_ready, supply_high, supply_low} = 5'h10;
		{overrange, flash_update_fail, mem_check_done} = 3'h0;
		{mem_check_fail, gpio_out, gpio_oe} = 5'h00;
		sensor = '0;
		repeat (6) @(negedge clock);
		sys_rst = 1'b0;
		repeat (3) @(negedge clock);
		t_regs();
		t_diag();
		t_manual();
		t_selftest(14'h0100, 16'h0000);
		t_sources();
		t_selftest(14'h0010, 16'h0020);
		t_memtest();
		t_roc();
		end_sim();
	end

	// Run needs about 1.2 ms; a hang is cut short well after that
	initial
	begin
		#5000000;
		failures++;
		end_sim();
	end
endmodule

//--- sim/host_spi_model.sv
// Purpose: Host processor model acting as serial port master
// Assumes: Mode 3 frames, 800 ns serial clock period, MSB first
// Notes: Serial clock stands high between frames; data line idles inverted
`timescale 1ns/100ps
module host_spi_model
(
	input wire logic clock,
	input wire logic spi_sdo,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_sdi
);
	// ------------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------------
	// Idle state: deselected, clock parked high
	initial
	begin
		spi_sclk = 1'b1;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b1;
	end

	// Reply bits are taken late in each bit because the device lags
	// by its synchroniser; a short count makes a deliberately bad frame
	task automatic xfer(input logic [15:0] din, input int nbits,
		output logic [15:0] dout);
		int i;
		dout = 16'h0000;
		@(negedge clock);
		spi_cs_n = 1'b0;
		#800;
		for (i = 0; i < nbits; i++)
		begin
			dout = {dout[14:0], spi_sdo};
			spi_sclk = 1'b0;
			spi_sdi = din[15 - i];
			#400;
			spi_sclk = 1'b1;
			#400;
		end
		spi_sdi = ~spi_sdi;
		spi_cs_n = 1'b1;
		#1000;
	endtask
endmodule
